// >>> core/pcdmux_consts.vh
// constants for the port c/d alternate function mux
`ifndef PCDMUX_CONSTS_VH
`define PCDMUX_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PCDMUX_OFF_PC_OUT   8'h00
`define PCDMUX_OFF_PC_DIR   8'h04
`define PCDMUX_OFF_PC_PIN   8'h08
`define PCDMUX_OFF_PD_OUT   8'h0C
`define PCDMUX_OFF_PD_DIR   8'h10
`define PCDMUX_OFF_PD_PIN   8'h14
`define PCDMUX_OFF_CTRL     8'h18
`define PCDMUX_OFF_IRQ_EN   8'h1C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PCDMUX_CTRL_PULLOFF 0
`define PCDMUX_CTRL_TXEN    1
`define PCDMUX_CTRL_RXEN    2
`define PCDMUX_CTRL_SYNC    3
`define PCDMUX_CTRL_CTSEN   4
`define PCDMUX_CTRL_RTSEN   5
`define PCDMUX_CTRL_T0CMPB  6
`define PCDMUX_CTRL_T1CMPA  7
`define PCDMUX_CTRL_T1CMPB  8
`define PCDMUX_CTRL_CMPEN   9
`define PCDMUX_CTRL_INOFF   10
`define PCDMUX_CTRL_W       11

// ----------------------------------------------------------------
// interrupt enable fields: ext_irq 7..0 low, pin change 12..8 high
// ----------------------------------------------------------------
`define PCDMUX_IRQ_EXT_LSB  0
`define PCDMUX_IRQ_PCH_LSB  8
`define PCDMUX_IRQ_W        13

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define PCDMUX_RST_PORT     8'h00
`define PCDMUX_RST_CTRL     11'h000
`define PCDMUX_RST_IRQ      13'h0000
`define PCDMUX_PC_MASK      8'hF7

`endif

// >>> core/pcdmux_top.v
// port c/d alternate function override mux with apb register access
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "pcdmux_consts.vh"

module pcdmux_top (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // port c pads
  input  wire [7:0]  pc_pin_in,
  output reg  [7:0]  pc_pin_out,
  output reg  [7:0]  pc_pin_oe,
  output reg  [7:0]  pc_pin_pullup,
  // port d pads
  input  wire [7:0]  pd_pin_in,
  output reg  [7:0]  pd_pin_out,
  output reg  [7:0]  pd_pin_oe,
  output reg  [7:0]  pd_pin_pullup,
  // values from the peripherals
  input  wire        serial_tx_line,
  input  wire        serial_rts_state,
  input  wire        serial_ext_clock_out,
  input  wire        timer0_cmp_b_out,
  input  wire        timer1_cmp_a_out,
  input  wire        timer1_cmp_b_out,
  // levels to the peripherals
  output wire        serial_rx_line,
  output wire        serial_ext_clock_in,
  output wire        serial_tx_allow,
  output wire        timer0_count_in,
  output wire [7:0]  ext_irq,
  output wire [12:8] pin_change_src,
  output wire        cmp_pos_in,
  output wire        cmp_neg_in
);

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // port halves, control and interrupt enables; all clear on reset
  reg [7:0]                 pc_out_r;
  reg [7:0]                 pc_dir_r;
  reg [7:0]                 pd_out_r;
  reg [7:0]                 pd_dir_r;
  reg [`PCDMUX_CTRL_W-1:0]  ctrl_r;
  reg [`PCDMUX_IRQ_W-1:0]   irq_en_r;

  // bus decode and read path
  wire                      wr_en;
  wire                      rd_setup;
  wire                      addr_ok;
  reg  [31:0]               rd_nxt;

  // control fields; inputs_off turns off every digital input that no
  // override holds on
  wire global_pullup_off = ctrl_r[`PCDMUX_CTRL_PULLOFF];
  wire tx_enable_bit     = ctrl_r[`PCDMUX_CTRL_TXEN];
  wire rx_enable_bit     = ctrl_r[`PCDMUX_CTRL_RXEN];
  wire sync_mode         = ctrl_r[`PCDMUX_CTRL_SYNC];
  wire cts_en            = ctrl_r[`PCDMUX_CTRL_CTSEN];
  wire rts_en            = ctrl_r[`PCDMUX_CTRL_RTSEN];
  wire t0_cmpb_en        = ctrl_r[`PCDMUX_CTRL_T0CMPB];
  wire t1_cmpa_en        = ctrl_r[`PCDMUX_CTRL_T1CMPA];
  wire t1_cmpb_en        = ctrl_r[`PCDMUX_CTRL_T1CMPB];
  wire cmp_en            = ctrl_r[`PCDMUX_CTRL_CMPEN];
  wire inputs_off        = ctrl_r[`PCDMUX_CTRL_INOFF];

  // interrupt enables: external sources low, pin-change sources high
  wire [7:0] ext_en = irq_en_r[`PCDMUX_IRQ_EXT_LSB+7:`PCDMUX_IRQ_EXT_LSB];
  wire [4:0] pch_en = irq_en_r[`PCDMUX_IRQ_PCH_LSB+4:`PCDMUX_IRQ_PCH_LSB];

  // ----------------------------------------------------------------
  // pad input synchronisers
  // ----------------------------------------------------------------
  // three stages; the filtered level only moves when stages two and
  // three agree, so a single metastable resolve cannot glitch it;
  // the cost is up to four edges from pad to level, and stage one
  // feeds stage two only
  reg [15:0] sync1_r;
  reg [15:0] sync2_r;
  reg [15:0] sync3_r;
  reg [15:0] pin_lvl_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r   <= 16'h0000;
      sync2_r   <= 16'h0000;
      sync3_r   <= 16'h0000;
      pin_lvl_r <= 16'h0000;
    end else begin
      sync1_r   <= {pd_pin_in, pc_pin_in};
      sync2_r   <= sync1_r;
      sync3_r   <= sync2_r;
      pin_lvl_r <= (sync2_r & sync3_r) | (pin_lvl_r & (sync2_r | sync3_r));
    end
  end

  // ----------------------------------------------------------------
  // override vectors, bit n of port c at n, port d at n+8
  // ----------------------------------------------------------------
  wire [15:0] pu_oe;
  wire [15:0] pu_ov;
  wire [15:0] dd_oe;
  wire [15:0] dd_ov;
  wire [15:0] ser_pv_oe;
  wire [15:0] ser_pv_ov;
  wire [15:0] tmr_pv_oe;
  wire [15:0] tmr_pv_ov;
  wire [15:0] ie_oe;
  wire [15:0] ie_ov;

  // clock pin is only live in synchronous mode; then its direction bit
  // decides whether the clock is driven out
  wire xck_out_en = sync_mode & pd_dir_r[5];

  // port c never overrides pull-up or direction; bit 3 does not exist
  // and bits 1 and 0 carry no override of any kind
  assign pu_oe[7:0] = 8'h00;
  assign pu_ov[7:0] = 8'h00;
  assign dd_oe[7:0] = 8'h00;
  assign dd_ov[7:0] = 8'h00;

  // port d pull-up overrides: txd off, rxd/cts from out bit, rts zero;
  // forced inputs keep software's pull-up choice unless pull-ups are off
  assign pu_oe[15:8] = {cts_en, rts_en, 2'b00, tx_enable_bit, rx_enable_bit, 2'b00};
  assign pu_ov[15:8] = {pd_out_r[7] & ~global_pullup_off,
                        1'b0,
                        2'b00,
                        1'b0,
                        pd_out_r[2] & ~global_pullup_off,
                        2'b00};

  // port d direction overrides; a forced pin ignores the direction bit
  // that software left behind
  assign dd_oe[15:8] = {cts_en, rts_en, 2'b00, tx_enable_bit, rx_enable_bit, 2'b00};
  assign dd_ov[15:8] = {1'b0,
                        1'b1,
                        2'b00,
                        1'b1,
                        1'b0,
                        2'b00};

  // serial and flow-control value overrides; pd5 carries the clock only
  // in synchronous mode and as an output
  assign ser_pv_oe = {1'b0, rts_en, xck_out_en, 1'b0, tx_enable_bit, 3'b000, 8'h00};
  assign ser_pv_ov = {1'b0, serial_rts_state,
                      serial_ext_clock_out,
                      1'b0, serial_tx_line,
                      3'b000, 8'h00};

  // timer compare value overrides; direction stays with software, so
  // the waveform reaches a pad only when its direction bit is set
  assign tmr_pv_oe = {7'h00, t0_cmpb_en, 1'h0, t1_cmpa_en, t1_cmpb_en, 5'h00};
  assign tmr_pv_ov = {7'h00, timer0_cmp_b_out,
                      1'b0, timer1_cmp_a_out, timer1_cmp_b_out,
                      5'h00};

  // input-enable overrides; comparator pins follow the comparator
  // enable unless an interrupt needs the digital path
  assign ie_oe[7:0]  = {ext_en[4], pch_en[0], pch_en[1], pch_en[2], 1'b0,
                        pch_en[3], 2'b00};
  assign ie_ov[7:0]  = {4'hF, 1'b0, 1'b1, 2'b00};
  // port d: every interrupt enable forces its pin's digital input on
  assign ie_oe[15:8] = {ext_en[7] | cts_en,
                        ext_en[6],
                        pch_en[4],
                        ext_en[5],
                        ext_en[3],
                        ext_en[2] | cmp_en,
                        ext_en[1] | cmp_en,
                        ext_en[0]};
  assign ie_ov[15:8] = {5'h1F,
                        ext_en[2] | cmp_en,
                        ext_en[1] | cmp_en,
                        1'b1};

  // ----------------------------------------------------------------
  // per-pad resolution
  // ----------------------------------------------------------------
  // port c bit 3 is masked so that it stays inert on every path
  wire [15:0] reg_out = {pd_out_r, pc_out_r & `PCDMUX_PC_MASK};
  wire [15:0] reg_dir = {pd_dir_r, pc_dir_r & `PCDMUX_PC_MASK};
  // resolved pad controls and gated digital input levels
  wire [15:0] fin_pu;
  wire [15:0] fin_dir;
  wire [15:0] fin_val;
  wire [15:0] fin_ie;
  wire [15:0] pin_di;

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pad
      // register-derived pull-up: input with out bit set, unless disabled
      wire reg_pu = ~reg_dir[gi] & reg_out[gi] & ~global_pullup_off;
      // serial claims rank ahead of timer claims on the same pin;
      // a timer claim on a serial pin would otherwise corrupt the line
      wire pv_oe  = ser_pv_oe[gi] | tmr_pv_oe[gi];
      wire pv_ov  = ser_pv_oe[gi] ? ser_pv_ov[gi] : tmr_pv_ov[gi];
      assign fin_pu[gi]  = pu_oe[gi] ? pu_ov[gi] : reg_pu;
      assign fin_dir[gi] = dd_oe[gi] ? dd_ov[gi] : reg_dir[gi];
      assign fin_val[gi] = pv_oe ? pv_ov : reg_out[gi];
      assign fin_ie[gi]  = ie_oe[gi] ? ie_ov[gi] : ~inputs_off;
      // a disabled digital input reads as zero
      assign pin_di[gi]  = fin_ie[gi] & pin_lvl_r[gi];
    end
  endgenerate

  // pad drive is registered so that the pins never see decode glitches;
  // the cost is one cycle from a control change to the pad;
  // pull-ups are masked while the pad drives so they never fight it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_pin_out    <= 8'h00;
      pc_pin_oe     <= 8'h00;
      pc_pin_pullup <= 8'h00;
      pd_pin_out    <= 8'h00;
      pd_pin_oe     <= 8'h00;
      pd_pin_pullup <= 8'h00;
    end else begin
      pc_pin_out    <= fin_val[7:0];
      pc_pin_oe     <= fin_dir[7:0];
      pc_pin_pullup <= fin_pu[7:0] & ~fin_dir[7:0];
      pd_pin_out    <= fin_val[15:8];
      pd_pin_oe     <= fin_dir[15:8];
      pd_pin_pullup <= fin_pu[15:8] & ~fin_dir[15:8];
    end
  end

  // ----------------------------------------------------------------
  // levels to the peripherals
  // ----------------------------------------------------------------
  // the receiver sees zero while it is off, so a stray edge cannot start a frame
  assign serial_rx_line      = rx_enable_bit & pin_di[10];
  assign serial_ext_clock_in = sync_mode & ~pd_dir_r[5] & pin_di[13];
  // clear-to-send is active low: a high pin holds the transmitter;
  // the event counter shares that pad and sees the same gated level
  assign serial_tx_allow     = ~cts_en | ~pin_di[15];
  assign timer0_count_in     = pin_di[15];
  assign ext_irq             = {pin_di[15], pin_di[14], pin_di[12], pin_di[7],
                                pin_di[11], pin_di[10], pin_di[9], pin_di[8]};
  assign pin_change_src      = {pin_di[13], pin_di[2], pin_di[4], pin_di[5],
                                pin_di[6]};
  // interrupt sources above take the gated level, while the
  // comparator taps the pad level before digital input gating
  assign cmp_neg_in          = pin_lvl_r[10];
  assign cmp_pos_in          = pin_lvl_r[9];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // zero wait state; read data is captured in the setup cycle,
  // so every access phase completes at its first edge
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable;
  assign addr_ok  = (paddr == `PCDMUX_OFF_PC_OUT) | (paddr == `PCDMUX_OFF_PC_DIR) |
                    (paddr == `PCDMUX_OFF_PC_PIN) | (paddr == `PCDMUX_OFF_PD_OUT) |
                    (paddr == `PCDMUX_OFF_PD_DIR) | (paddr == `PCDMUX_OFF_PD_PIN) |
                    (paddr == `PCDMUX_OFF_CTRL)   | (paddr == `PCDMUX_OFF_IRQ_EN);
  // unmapped addresses and writes to the read-only pin registers fail
  assign pslverr  = psel & penable & (~addr_ok | (pwrite &
                    ((paddr == `PCDMUX_OFF_PC_PIN) | (paddr == `PCDMUX_OFF_PD_PIN))));

  // register writes land at the access edge of a mapped address;
  // port c bit 3 always stores zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_out_r <= `PCDMUX_RST_PORT;
      pc_dir_r <= `PCDMUX_RST_PORT;
      pd_out_r <= `PCDMUX_RST_PORT;
      pd_dir_r <= `PCDMUX_RST_PORT;
      ctrl_r   <= `PCDMUX_RST_CTRL;
      irq_en_r <= `PCDMUX_RST_IRQ;
    end else if (wr_en) begin
      case (paddr)
        `PCDMUX_OFF_PC_OUT: pc_out_r <= pwdata[7:0] & `PCDMUX_PC_MASK;
        `PCDMUX_OFF_PC_DIR: pc_dir_r <= pwdata[7:0] & `PCDMUX_PC_MASK;
        `PCDMUX_OFF_PD_OUT: pd_out_r <= pwdata[7:0];
        `PCDMUX_OFF_PD_DIR: pd_dir_r <= pwdata[7:0];
        `PCDMUX_OFF_CTRL:   ctrl_r   <= pwdata[`PCDMUX_CTRL_W-1:0];
        `PCDMUX_OFF_IRQ_EN: irq_en_r <= pwdata[`PCDMUX_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // read multiplexer
  // unused upper bits and unmapped offsets read as zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `PCDMUX_OFF_PC_OUT: rd_nxt[7:0] = pc_out_r;
      `PCDMUX_OFF_PC_DIR: rd_nxt[7:0] = pc_dir_r;
      `PCDMUX_OFF_PC_PIN: rd_nxt[7:0] = pin_di[7:0] & `PCDMUX_PC_MASK;
      `PCDMUX_OFF_PD_OUT: rd_nxt[7:0] = pd_out_r;
      `PCDMUX_OFF_PD_DIR: rd_nxt[7:0] = pd_dir_r;
      `PCDMUX_OFF_PD_PIN: rd_nxt[7:0] = pin_di[15:8];
      `PCDMUX_OFF_CTRL:   rd_nxt[`PCDMUX_CTRL_W-1:0] = ctrl_r;
      `PCDMUX_OFF_IRQ_EN: rd_nxt[`PCDMUX_IRQ_W-1:0] = irq_en_r;
      default:            rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data held from the setup edge through the access phase;
  // a write setup clears it so stale read data never lingers on the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
    end
  end

endmodule

// >>> dv/pcdmux_top_sva.sv
// concurrent checks on the port c/d override mux ports
`timescale 1ns/1ns
module pcdmux_sva (
  // clock, reset and apb
  input wire        pclk, presetn, psel, penable, pwrite, pslverr,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  // pads and peripheral values
  input wire [7:0]  pd_pin_out, pd_pin_oe, pd_pin_pullup, pc_pin_pullup,
  input wire        serial_tx_line, serial_rts_state, timer0_cmp_b_out
);
  reg [10:0] ctrl_r;
  // shadow of control writes; the pads show it one edge after the store
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_r <= 11'h000;
    else if (psel && penable && pwrite && paddr == 8'h18)
      ctrl_r <= pwdata[10:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable;
  endsequence
  tx_drive_a: assert property ($past(ctrl_r[1]) |-> pd_pin_oe[3] && pd_pin_out[3] == $past(serial_tx_line))
    else $error("pd3 not carrying the transmit line");
  rx_input_a: assert property ($past(ctrl_r[2]) |-> !pd_pin_oe[2])
    else $error("pd2 driven while receiver on");
  cts_input_a: assert property ($past(ctrl_r[4]) |-> !pd_pin_oe[7])
    else $error("pd7 driven while transmit flow control on");
  rts_drive_a: assert property ($past(ctrl_r[5]) |-> pd_pin_oe[6] && pd_pin_out[6] == $past(serial_rts_state))
    else $error("pd6 not carrying the request state");
  cmp_value_a: assert property ($past(ctrl_r[6]) |-> pd_pin_out[0] == $past(timer0_cmp_b_out))
    else $error("pd0 not carrying the timer compare output");
  pullup_off_a: assert property ($past(ctrl_r[0]) |-> pd_pin_pullup == 8'h00 && pc_pin_pullup == 8'h00)
    else $error("pull-up on while pull-ups are off");
  unmapped_err_a: assert property (acc_s ##0 (paddr > 8'h1C) |-> pslverr)
    else $error("unmapped access not refused");
  pin_write_err_a: assert property (acc_s ##0 (pwrite && (paddr == 8'h08 || paddr == 8'h14)) |-> pslverr)
    else $error("write to a pin level register not refused");
endmodule

// >>> dv/pcdmux_pads.sv
// board-side pad model: block drive, board drive, pull-up, else a wandering level
`timescale 1ns/1ns
module pcdmux_pads (
  // clock for the floating pattern
  input  wire       pclk,
  // pad controls from the block
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [7:0] pin_pullup,
  // board drive from the bench
  input  wire [7:0] ext_en,
  input  wire [7:0] ext_val,
  // level seen at the pad inputs
  output wire [7:0] pin_in
);
  reg [7:0] float_r = 8'h55;
  // an open pin must not keep its last level, so it toggles every cycle
  always @(posedge pclk) begin
    float_r <= ~float_r;
  end
  // block drive wins, then the board, then the pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & (pin_pullup | float_r));
endmodule

// >>> dv/pcdmux_top_tb.sv
// self-checking bench for the port c/d override mux
`timescale 1ns/1ns
module pcdmux_top_tb;
  logic        pclk = 1'h0;
  logic        presetn, psel, penable, pwrite, err_q;
  logic [7:0]  paddr, c_en, c_val, d_en, d_val;
  logic [31:0] pwdata, rd_q;
  logic        serial_tx_line, serial_rts_state, serial_ext_clock_out;
  logic        timer0_cmp_b_out, timer1_cmp_a_out, timer1_cmp_b_out;
  wire         pready, pslverr, serial_rx_line, serial_ext_clock_in, serial_tx_allow;
  wire         timer0_count_in, cmp_pos_in, cmp_neg_in;
  wire  [31:0] prdata;
  wire  [7:0]  pc_pin_in, pc_pin_out, pc_pin_oe, pc_pin_pullup, ext_irq;
  wire  [7:0]  pd_pin_in, pd_pin_out, pd_pin_oe, pd_pin_pullup;
  wire  [12:8] pin_change_src;
  int          n_errors, total_checks, cyc;
  pcdmux_top pcdmux_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .pc_pin_in, .pc_pin_out, .pc_pin_oe, .pc_pin_pullup, .pd_pin_in, .pd_pin_out,
    .pd_pin_oe, .pd_pin_pullup, .serial_tx_line, .serial_rts_state, .serial_ext_clock_out,
    .timer0_cmp_b_out, .timer1_cmp_a_out, .timer1_cmp_b_out, .serial_rx_line, .serial_ext_clock_in,
    .serial_tx_allow, .timer0_count_in, .ext_irq, .pin_change_src, .cmp_pos_in, .cmp_neg_in);
  pcdmux_pads pc_pads_inst (.pclk, .pin_out(pc_pin_out), .pin_oe(pc_pin_oe), .pin_pullup(pc_pin_pullup),
    .ext_en(c_en), .ext_val(c_val), .pin_in(pc_pin_in));
  pcdmux_pads pd_pads_inst (.pclk, .pin_out(pd_pin_out), .pin_oe(pd_pin_oe), .pin_pullup(pd_pin_pullup),
    .ext_en(d_en), .ext_val(d_val), .pin_in(pd_pin_in));
  always #2 pclk = ~pclk;
  // a hung handshake ends the run here instead of in the simulator
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // pads lag one edge, input levels up to four more
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic t_regs();
    apb(1'h0, 8'h18, 32'h0);
    chk(rd_q, 32'h0);
    apb(1'h1, 8'h04, 32'hFF);
    apb(1'h0, 8'h04, 32'h0);
    chk(rd_q, 32'hF7);
    chk(err_q, 1'h0);
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    chk({err_q, rd_q[7:0]}, 9'h100);
    apb(1'h1, 8'h08, 32'hFF);
    chk(err_q, 1'h1);
    $display("t_regs done");
  endtask
  task automatic t_outs();
    apb(1'h1, 8'h0C, 32'h20);
    apb(1'h1, 8'h10, 32'h21);
    apb(1'h1, 8'h18, 32'h4A);
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      serial_tx_line <= v[0];
      timer0_cmp_b_out <= ~v[0];
      serial_ext_clock_out <= v[0];
      settle(2);
      chk({pd_pin_oe[3], pd_pin_out[3], pd_pin_pullup[3]}, {1'h1, v[0], 1'h0});
      chk({pd_pin_oe[0], pd_pin_out[0]}, {1'h1, ~v[0]});
      chk({pd_pin_oe[5], pd_pin_out[5]}, {1'h1, v[0]});
    end
    @(posedge pclk);
    serial_ext_clock_out <= 1'h0;
    apb(1'h1, 8'h18, 32'h0);
    settle(2);
    chk({pd_pin_oe[3], pd_pin_oe[5], pd_pin_out[5]}, 3'h3);
    $display("t_outs done");
  endtask
  task automatic t_rx();
    apb(1'h1, 8'h0C, 32'hFF);
    apb(1'h1, 8'h10, 32'h04);
    apb(1'h1, 8'h00, 32'hFF);
    apb(1'h1, 8'h18, 32'h04);
    @(posedge pclk);
    d_en <= 8'h04;
    d_val <= 8'h04;
    settle(8);
    chk({pd_pin_oe[2], pd_pin_pullup}, 9'h0FF);
    chk({serial_rx_line, cmp_neg_in}, 2'h3);
    apb(1'h1, 8'h18, 32'h05);
    settle(2);
    chk({pd_pin_pullup, pc_pin_pullup}, 16'h0);
    apb(1'h1, 8'h18, 32'h0);
    settle(2);
    chk({pd_pin_oe[2], pd_pin_pullup, pc_pin_pullup}, 17'h1FBF7);
    apb(1'h1, 8'h0C, 32'h0);
    apb(1'h1, 8'h00, 32'h0);
    $display("t_rx done");
  endtask
  task automatic t_flow();
    apb(1'h1, 8'h10, 32'h80);
    apb(1'h1, 8'h18, 32'h30);
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      serial_rts_state <= v[0];
      d_en <= 8'h80;
      d_val <= {v[0], 7'h0};
      settle(8);
      chk({pd_pin_oe[7:6], pd_pin_out[6], pd_pin_pullup[6]}, {2'h1, v[0], 1'h0});
      chk({serial_tx_allow, timer0_count_in}, {~v[0], v[0]});
    end
    $display("t_flow done");
  endtask
  task automatic t_irq();
    logic [7:0] pd;
    logic [7:0] pc;
    apb(1'h1, 8'h10, 32'h0);
    apb(1'h1, 8'h04, 32'h60);
    apb(1'h1, 8'h18, 32'h188);
    apb(1'h1, 8'h1C, 32'h1FFF);
    for (int k = 0; k < 2; k++) begin
      pd = k[0] ? 8'h5A : 8'hA5;
      pc = k[0] ? 8'h6B : 8'h94;
      @(posedge pclk);
      {d_en, d_val, c_en, c_val} <= {8'hFF, pd, 8'hFF, pc};
      {timer1_cmp_a_out, timer1_cmp_b_out} <= {k[0], ~k[0]};
      settle(8);
      chk({pc_pin_oe[6:5], pc_pin_out[6:5]}, {2'h3, k[0], ~k[0]});
      chk(ext_irq, {pd[7], pd[6], pd[4], pc[7], pd[3:0]});
      chk(pin_change_src, {pd[5], pc[2], pc[4], ~k[0], k[0]});
      chk(serial_ext_clock_in, pd[5]);
      chk({cmp_pos_in, cmp_neg_in}, {pd[1], pd[2]});
    end
    $display("t_irq done");
  endtask
  // digital inputs off, comparator on: only pd1/pd2 read back, comparator sees raw levels
  task automatic t_inoff();
    apb(1'h1, 8'h1C, 32'h0);
    apb(1'h1, 8'h18, 32'h600);
    apb(1'h0, 8'h14, 32'h0);
    chk(rd_q, 32'h02);
    settle(1);
    chk({cmp_pos_in, cmp_neg_in, serial_rx_line}, 3'h4);
    $display("t_inoff done");
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {serial_tx_line, serial_rts_state, serial_ext_clock_out} = '0;
    {timer0_cmp_b_out, timer1_cmp_a_out, timer1_cmp_b_out} = '0;
    {c_en, c_val, d_en, d_val} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_outs();
    t_rx();
    t_flow();
    t_irq();
    t_inoff();
    results();
  end
endmodule
bind pcdmux_top pcdmux_sva pcdmux_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .paddr,
  .pwdata, .pd_pin_out, .pd_pin_oe, .pd_pin_pullup, .pc_pin_pullup, .serial_tx_line, .serial_rts_state,
  .timer0_cmp_b_out);
